// File: rtl/lcdcr_core.sv
/*
  Digital core of a 160-output LCD driver, column or row function.
  Pins arrive asynchronously and are sampled on ref_clk (25 MHz); strobe edges are found
  after synchronisation, so strobe high and low times must each exceed three clock periods.
  Captured words pass an 8-word FIFO into the first latch bank.
*/
// Behaviour
// - Each output picks one of four levels from AC phase and its bit.
// - Column mode: second latch copies first bank on falling line strobe.
// - Row mode: second latch is a shift register fed from enable input.
// - Direction high shifts bit 1 toward 160; low shifts 160 toward 1.
// - Count select high: only outputs 41 to 120 ever change their display bit.
// - Wide mode: twenty 8-bit slots (ten at 80 outputs) capture all eight data inputs.
// - Narrow mode: forty 4-bit slots (twenty at 80 outputs) capture data inputs 0 to 3.
// - Selector is a 6-bit up/down counter stepping on shift strobe.
// - When the first bank is full, latching stops to save power.
// - Capture only while enable is low, one word per falling shift strobe.
// - Full line: enter standby and drive chain output low.
// - 160 outputs: direction low maps first bit to output 1, high reverses.
// - 80 outputs: direction low maps first bit to output 41, high reverses.
// - Row 160 mode: chain output is scan input delayed 160 edges.
// - Row 80 mode: scan uses outputs 41 to 120, delay 80 edges.
// - Column mode: enable high blocks capture, low allows it.
// - Bit one drives the on level, bit zero the off level.
`timescale 1ns/1ps
module lcdcr_core (
  input  wire logic                   ref_clk,             // Core clock, 25 MHz
  input  wire logic                   rst_n,               // Asynchronous reset, active low
  input  wire logic                   clk_en,              // Freezes all state while low
  input  wire logic                   line_strobe,         // Line transfer strobe pin
  input  wire logic                   shift_strobe,        // Data shift strobe pin
  input  wire logic                   enable_in_n,         // Chain enable / scan data in
  input  wire logic                   ac_phase,            // Alternating drive phase pin
  input  wire logic [7:0]             display_data_in,     // Display data pins
  input  wire logic                   shift_direction,     // Shift direction pin
  input  wire logic                   input_width_select,  // High 8-bit, low 4-bit
  input  wire logic                   function_select,     // High column, low row
  input  wire logic                   output_count_select, // Low 160, high 80 outputs
  output logic                        chain_enable_out_n,  // Chain enable / scan out
  output logic                        capture_ready,       // FIFO has room for a word
  output logic                        standby,             // Line captured, latching idle
  output lcdcr_pkg::lcdcr_level_t [lcdcr_pkg::NUM_OUT-1:0] drive_outputs // Level codes
);
  localparam int N = lcdcr_pkg::NUM_OUT;

  lcdcr_pkg::lcdcr_pins_t  pins_raw;
  lcdcr_pkg::lcdcr_pins_t  pins_s1;
  lcdcr_pkg::lcdcr_pins_t  pins_s2;
  logic                    shift_d;
  logic                    line_d;
  logic                    shift_fall;
  logic                    line_fall;
  logic                    col;
  logic                    dir;
  logic [7:0]              idx_lo;
  logic [7:0]              idx_hi;
  logic [3:0]              wbits;
  logic [5:0]              slot_last;
  logic [5:0]              slot_start;
  logic [5:0]              slot_now;
  lcdcr_pkg::lcdcr_state_t st;
  lcdcr_pkg::lcdcr_state_t next_st;
  logic [5:0]              sel;
  logic [5:0]              next_sel;
  logic                    chain_col;
  logic                    next_chain_col;
  logic                    push;
  lcdcr_pkg::lcdcr_word_t  fifo_in;
  lcdcr_pkg::lcdcr_word_t  fifo_out;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [N-1:0]            lat1;
  logic [N-1:0]            next_lat1;
  logic [N-1:0]            lat2;
  logic [N-1:0]            next_lat2;

  // Gather pins so one two-stage synchroniser keeps data aligned with its strobe
  assign pins_raw = '{data: display_data_in, enable_n: enable_in_n, ac_phase: ac_phase,
                      shift_dir: shift_direction, width_sel: input_width_select,
                      func_sel: function_select, count_sel: output_count_select,
                      line_stb: line_strobe, shift_stb: shift_strobe};

  // Synchroniser; the edge detectors read only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      shift_d <= 1'b0;
      line_d  <= 1'b0;
    end else if (clk_en) begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      shift_d <= pins_s2.shift_stb;
      line_d  <= pins_s2.line_stb;
    end
  end

  assign shift_fall = shift_d && !pins_s2.shift_stb;
  assign line_fall  = line_d && !pins_s2.line_stb;
  assign col        = pins_s2.func_sel;
  assign dir        = pins_s2.shift_dir;

  // Mode-dependent geometry of the active window and the slot range
  always_comb begin
    idx_lo = pins_s2.count_sel ? lcdcr_pkg::IDX_LO_80 : lcdcr_pkg::IDX_ZERO;
    idx_hi = pins_s2.count_sel ? lcdcr_pkg::IDX_HI_80 : lcdcr_pkg::IDX_HI_160;
    wbits  = pins_s2.width_sel ? lcdcr_pkg::BITS_WIDE : lcdcr_pkg::BITS_NARROW;
    case ({pins_s2.count_sel, pins_s2.width_sel})
      2'b01:   slot_last = lcdcr_pkg::SLOT_LAST_160W8;
      2'b00:   slot_last = lcdcr_pkg::SLOT_LAST_160W4;
      2'b11:   slot_last = lcdcr_pkg::SLOT_LAST_80W8;
      default: slot_last = lcdcr_pkg::SLOT_LAST_80W4;
    endcase
    // Counting down from the top slot reverses the output order
    slot_start = dir ? slot_last : lcdcr_pkg::SLOT_FIRST;
    slot_now   = (st == lcdcr_pkg::ST_IDLE) ? slot_start : sel;
  end

  // Capture sequencer: selector counter, standby and the column chain enable
  always_comb begin
    next_st        = st;
    next_sel       = sel;
    next_chain_col = chain_col;
    push           = 1'b0;
    if (!col) begin
      next_st        = lcdcr_pkg::ST_IDLE;
      next_sel       = slot_start;
      next_chain_col = 1'b1;
    end else if (line_fall) begin
      // A new line restarts the selector and wakes the stage
      next_st        = lcdcr_pkg::ST_IDLE;
      next_sel       = slot_start;
      next_chain_col = 1'b1;
    end else begin
      case (st)
        lcdcr_pkg::ST_IDLE,
        lcdcr_pkg::ST_CAPTURE: begin
          if (st == lcdcr_pkg::ST_IDLE) begin
            next_sel = slot_start;
          end
          // A full FIFO drops the word, so capture_ready must be watched upstream
          if (shift_fall && !pins_s2.enable_n && fifo_in_ready) begin
            push    = 1'b1;
            next_st = lcdcr_pkg::ST_CAPTURE;
            if (slot_now == (dir ? lcdcr_pkg::SLOT_FIRST : slot_last)) begin
              next_st        = lcdcr_pkg::ST_STANDBY;
              next_chain_col = 1'b0;
            end else begin
              next_sel = dir ? slot_now - lcdcr_pkg::SLOT_STEP
                             : slot_now + lcdcr_pkg::SLOT_STEP;
            end
          end
        end
        lcdcr_pkg::ST_STANDBY: begin
          next_st = lcdcr_pkg::ST_STANDBY;
        end
        default: begin
          next_st = lcdcr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= lcdcr_pkg::ST_IDLE;
      sel       <= lcdcr_pkg::SLOT_FIRST;
      chain_col <= 1'b1;
    end else if (clk_en) begin
      st        <= next_st;
      sel       <= next_sel;
      chain_col <= next_chain_col;
    end
  end

  assign fifo_in = '{slot: slot_now, data: pins_s2.data};
  // Drain stalls while the line transfer reads the bank, so no write races the copy
  assign fifo_out_ready = !line_fall;

  lcdcr_fifo #(
    .WIDTH (lcdcr_pkg::WORD_W),
    .DEPTH (lcdcr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_data   (fifo_in),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // First latch bank: a drained word lands at its slot, bit order set by direction
  always_comb begin
    int off;
    off       = 0;
    next_lat1 = lat1;
    if (fifo_out_valid && fifo_out_ready) begin
      for (int k = 0; k < lcdcr_pkg::DATA_W; k++) begin
        if (k < int'(wbits)) begin
          off = int'(idx_lo) + int'(fifo_out.slot) * int'(wbits)
              + (dir ? int'(wbits) - 1 - k : k);
          if (off < N) begin
            next_lat1[off] = fifo_out.data[k];
          end
        end
      end
    end
  end

  // Second latch: parallel copy in column mode, scan shift register in row mode
  always_comb begin
    next_lat2 = lat2;
    for (int i = 0; i < N; i++) begin
      if (i >= int'(idx_lo) && i <= int'(idx_hi)) begin
        if (col) begin
          if (line_fall) begin
            next_lat2[i] = lat1[i];
          end
        end else if (shift_fall) begin
          if (dir) begin
            next_lat2[i] = (i == int'(idx_lo)) ? pins_s2.enable_n
                                               : lat2[(i == 0) ? 0 : i - 1];
          end else begin
            next_lat2[i] = (i == int'(idx_hi)) ? pins_s2.enable_n
                                               : lat2[(i == N - 1) ? i : i + 1];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat1 <= '0;
      lat2 <= '0;
    end else if (clk_en) begin
      lat1 <= next_lat1;
      lat2 <= next_lat2;
    end
  end

  // Row mode passes on the bit leaving the window end; line length sets the delay
  assign chain_enable_out_n = col ? chain_col
                                  : (dir ? lat2[idx_hi] : lat2[idx_lo]);
  assign capture_ready      = fifo_in_ready;
  assign standby            = (st == lcdcr_pkg::ST_STANDBY);

  // One level selector per output
  for (genvar g = 0; g < N; g++) begin : g_out
    lcdcr_lvl_cell u_cell (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .ac_phase (pins_s2.ac_phase),
      .disp_bit (lat2[g]),
      .level    (drive_outputs[g])
    );
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  capture_gate_a: assert property (push |-> (col && shift_fall && !pins_s2.enable_n))
    else $error("Word captured without enable low on a shift edge");

  enable_block_a: assert property ((col && pins_s2.enable_n) |-> !push)
    else $error("Capture while enable high");

  standby_halt_a: assert property (standby |-> !push)
    else $error("Capture during standby");

  chain_low_a: assert property ((col && standby && !line_fall) |=> !chain_enable_out_n)
    else $error("Chain output not low in standby");

  slot_step_a: assert property ((push && next_st == lcdcr_pkg::ST_CAPTURE && !dir)
    |=> sel == $past(slot_now) + lcdcr_pkg::SLOT_STEP)
    else $error("Selector did not step up");

  line_restart_a: assert property ((col && line_fall && $stable(dir))
    |=> (st == lcdcr_pkg::ST_IDLE && chain_enable_out_n))
    else $error("Line strobe did not restart the stage");

  line_copy_a: assert property ((col && line_fall && !pins_s2.count_sel)
    |=> lat2 == $past(lat1))
    else $error("Second latch missed line transfer");

  keep_outside_a: assert property ((pins_s2.count_sel && $past(pins_s2.count_sel))
    |-> (lat2[39:0] == $past(lat2[39:0]) && lat2[159:120] == $past(lat2[159:120])))
    else $error("Output outside 41..120 changed in 80 mode");

  row_up_a: assert property ((!col && shift_fall && dir && !pins_s2.count_sel)
    |=> (lat2[0] == $past(pins_s2.enable_n) && lat2[159:1] == $past(lat2[158:0])))
    else $error("Upward scan shift wrong");

  row_down_a: assert property ((!col && shift_fall && !dir && !pins_s2.count_sel)
    |=> (lat2[159] == $past(pins_s2.enable_n) && lat2[158:0] == $past(lat2[159:1])))
    else $error("Downward scan shift wrong");

  row80_entry_a: assert property ((!col && shift_fall && dir && pins_s2.count_sel)
    |=> lat2[40] == $past(pins_s2.enable_n))
    else $error("80-output scan did not enter at output 41");

  row_chain_a: assert property ((!col && dir && !pins_s2.count_sel)
    |-> chain_enable_out_n == lat2[159])
    else $error("Row chain output not taken from bit 160");

endmodule : lcdcr_core

// File: rtl/lcdcr_pkg.sv
/*
  Shared constants, encodings and carrier types of the LCD column/row driver core.
  Assumes one clock domain; every user includes nothing and names items as lcdcr_pkg::name.
*/
package lcdcr_pkg;

  // Output array geometry
  localparam int            NUM_OUT     = 160;
  localparam int            DATA_W      = 8;
  localparam int            SLOT_W      = 6;
  localparam int            IDX_W       = 8;
  localparam int            FIFO_DEPTH  = 8;

  // Window bounds as bit indexes (output N sits at index N-1)
  localparam logic [7:0]    IDX_ZERO    = 8'h00;
  localparam logic [7:0]    IDX_LO_80   = 8'h28;  // Output 41
  localparam logic [7:0]    IDX_HI_80   = 8'h77;  // Output 120
  localparam logic [7:0]    IDX_HI_160  = 8'h9f;  // Output 160

  // Bits per captured word
  localparam logic [3:0]    BITS_WIDE   = 4'h8;
  localparam logic [3:0]    BITS_NARROW = 4'h4;

  // Last slot number of the first latch bank for each mode pair
  localparam logic [5:0]    SLOT_FIRST      = 6'h00;
  localparam logic [5:0]    SLOT_LAST_160W8 = 6'h13;  // Twenty 8-bit slots
  localparam logic [5:0]    SLOT_LAST_160W4 = 6'h27;  // Forty 4-bit slots
  localparam logic [5:0]    SLOT_LAST_80W8  = 6'h09;
  localparam logic [5:0]    SLOT_LAST_80W4  = 6'h13;
  localparam logic [5:0]    SLOT_STEP       = 6'h01;

  // Drive level codes: V1/V2 selected, V3/V4 nonselected
  typedef enum logic [1:0] {LVL_V1, LVL_V2, LVL_V3, LVL_V4} lcdcr_level_t;

  // Capture sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_STANDBY} lcdcr_state_t;

  // All pin inputs, synchronised together so strobe and data stay aligned
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              enable_n;
    logic              ac_phase;
    logic              shift_dir;
    logic              width_sel;
    logic              func_sel;
    logic              count_sel;
    logic              line_stb;
    logic              shift_stb;
  } lcdcr_pins_t;

  // One captured word with the slot that the selector gave it
  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] data;
  } lcdcr_word_t;

  localparam int WORD_W = $bits(lcdcr_word_t);

endpackage : lcdcr_pkg

// File: rtl/lcdcr_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock, active-low asynchronous reset and a freezing clock enable.
*/
`timescale 1ns/1ps
module lcdcr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,    // Core clock
  input  wire logic             rst_n,      // Asynchronous reset, active low
  input  wire logic             clk_en,     // Freezes all state while low
  input  wire logic [WIDTH-1:0] in_data,    // Word to store
  input  wire logic             in_valid,   // Store request
  output logic                  in_ready,   // Room for a word
  output logic [WIDTH-1:0]      out_data,   // Oldest word
  output logic                  out_valid,  // A word is waiting
  input  wire logic             out_ready   // Drain side takes the word
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             do_wr;
  logic             do_rd;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Pointer and count update; wrap is explicit so DEPTH need not be a power of two
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (do_wr) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
    if (do_rd) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
    if (do_wr && !do_rd) begin
      next_count = count + CW'(1);
    end else if (do_rd && !do_wr) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset; only words behind a valid count are ever read
  always_ff @(posedge ref_clk) begin
    if (clk_en && do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : lcdcr_fifo

// File: rtl/lcdcr_lvl_cell.sv
/*
  One drive output: picks a level code from the AC phase and its display bit.
  Assumes both inputs are already on the core clock.
*/
`timescale 1ns/1ps
module lcdcr_lvl_cell (
  input  wire logic            ref_clk,   // Core clock
  input  wire logic            rst_n,     // Asynchronous reset, active low
  input  wire logic            clk_en,    // Freezes state while low
  input  wire logic            ac_phase,  // Alternating drive phase
  input  wire logic            disp_bit,  // Display bit held for this output
  output lcdcr_pkg::lcdcr_level_t level   // Registered level code
);
  lcdcr_pkg::lcdcr_level_t next_level;

  // Four levels from two inputs; phase swaps polarity so the panel sees no DC
  always_comb begin
    case ({disp_bit, ac_phase})
      2'b11:   next_level = lcdcr_pkg::LVL_V1;
      2'b10:   next_level = lcdcr_pkg::LVL_V2;
      2'b01:   next_level = lcdcr_pkg::LVL_V4;
      default: next_level = lcdcr_pkg::LVL_V3;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= lcdcr_pkg::LVL_V3;
    end else if (clk_en) begin
      level <= next_level;
    end
  end

  // An on bit never shows a nonselected level one cycle later
  on_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
    disp_bit |=> (level == lcdcr_pkg::LVL_V1 || level == lcdcr_pkg::LVL_V2))
    else $error("On bit did not select an on level");

  // An off bit with phase high gives V4, the phase-high nonselected level
  phase_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
    (!disp_bit && ac_phase) |=> (level == lcdcr_pkg::LVL_V4))
    else $error("Off bit with phase high gave wrong level");

endmodule : lcdcr_lvl_cell

// File: tb/lcdcr_ctrl_model.sv
/*
  Controller-side pin driver for the LCD driver core: strobes, data, enable and AC phase.
  Assumes ref_clk is the core clock; strobes idle low and change only after a rising edge.
*/
`timescale 1ns/1ps
module lcdcr_ctrl_model (
  input  wire logic       ref_clk,          // Core clock
  output logic            line_strobe,      // Line strobe pin
  output logic            shift_strobe,     // Shift strobe pin
  output logic            enable_in_n,      // Enable or scan data
  output logic            ac_phase,         // AC phase pin
  output logic [7:0]      display_data_in   // Data pins
);
  // Idle pins at time zero
  initial begin
    line_strobe     = 1'b0;
    shift_strobe    = 1'b0;
    enable_in_n     = 1'b1;
    ac_phase        = 1'b0;
    display_data_in = 8'h00;
  end

  // One strobe pulse; widths keep clear of the core's three-clock edge detector
  task automatic pulse(input logic line, input logic [7:0] d, input logic en,
                       input logic ph);
    @(posedge ref_clk);
    display_data_in <= d;
    enable_in_n     <= en;
    ac_phase        <= ph;
    if (line) line_strobe <= 1'b1;
    else shift_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    line_strobe  <= 1'b0;
    shift_strobe <= 1'b0;
    repeat (6) @(posedge ref_clk);
    display_data_in <= ~d;  // Hold over: the word must not linger on the pins
  endtask : pulse
endmodule : lcdcr_ctrl_model

// File: tb/test_lcd_column_row_driver.sv
/*
  Self-checking bench for the LCD driver core: column lines in all four width/count modes, then row scans.
  Assumes lcdcr_pkg and the core are compiled first; the controller model drives strobes, data, enable and phase.
*/
`timescale 1ns/1ps
module test_lcd_column_row_driver;
  typedef lcdcr_pkg::lcdcr_level_t [159:0] lcdcr_row_t;
  logic         ref_clk, rst_n, clk_en, line_strobe, shift_strobe, enable_in_n, ac_phase;
  logic         shift_direction, input_width_select, function_select, output_count_select;
  logic [7:0]   display_data_in;
  logic         chain_enable_out_n, capture_ready, standby;
  lcdcr_row_t   drive_outputs;
  logic [159:0] exp_l1 = '0;
  logic [159:0] exp_l2 = '0;
  logic [2:0]   cfg [4] = '{3'b100, 3'b001, 3'b111, 3'b010};
  int           bad_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  lcdcr_core i_lcdcr_core (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .line_strobe(line_strobe), .shift_strobe(shift_strobe), .enable_in_n(enable_in_n),
    .ac_phase(ac_phase), .display_data_in(display_data_in), .shift_direction(shift_direction),
    .input_width_select(input_width_select), .function_select(function_select),
    .output_count_select(output_count_select), .chain_enable_out_n(chain_enable_out_n),
    .capture_ready(capture_ready), .standby(standby), .drive_outputs(drive_outputs));

  lcdcr_ctrl_model i_lcdcr_ctrl_model (.ref_clk(ref_clk), .line_strobe(line_strobe),
    .shift_strobe(shift_strobe), .enable_in_n(enable_in_n), .ac_phase(ac_phase),
    .display_data_in(display_data_in));

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Expected level code per output from the latch image and phase
  function automatic lcdcr_row_t levels(input logic [159:0] b, input logic ph);
    for (int i = 0; i < 160; i++)
      levels[i] = b[i] ? (ph ? lcdcr_pkg::LVL_V1 : lcdcr_pkg::LVL_V2)
                       : (ph ? lcdcr_pkg::LVL_V4 : lcdcr_pkg::LVL_V3);
  endfunction : levels

  task automatic check_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_out(input lcdcr_row_t exp);
    samples_checked++;
    if (drive_outputs !== exp) begin
      bad_count++;
      $display("BAD drive_outputs expected %h seen %h", exp, drive_outputs);
    end
  endtask : check_out

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n  <= 1'b1;
    exp_l2 = '0;
    @(negedge ref_clk);
    check_bit("standby", 1'b0, standby);
    // Cleared synchroniser reads as row mode, so chain shows the empty scan register
    check_bit("chain", 1'b0, chain_enable_out_n);
    check_bit("ready", 1'b1, capture_ready);
    check_out(levels(exp_l2, 1'b0));
  endtask : do_reset

  // Refused word, full line, refused word in standby, then the line transfer
  task automatic col_line(input logic w8, input logic c80, input logic dir);
    int w, base, n;
    logic [7:0] d;
    w    = w8 ? 8 : 4;
    base = c80 ? 40 : 0;
    n    = (c80 ? 80 : 160) / w;
    @(posedge ref_clk);
    input_width_select  <= w8;
    output_count_select <= c80;
    shift_direction     <= dir;
    i_lcdcr_ctrl_model.pulse(1'b0, 8'h5a, 1'b1, 1'($urandom));
    for (int s = 0; s < n; s++) begin
      d = 8'($urandom);
      i_lcdcr_ctrl_model.pulse(1'b0, d, 1'b0, 1'($urandom));
      for (int k = 0; k < w; k++)
        exp_l1[base + (dir ? (n-1-s)*w + w-1-k : s*w + k)] = d[k];
    end
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check_bit("standby", 1'b1, standby);
    check_bit("chain", 1'b0, chain_enable_out_n);
    i_lcdcr_ctrl_model.pulse(1'b0, 8'hff, 1'b0, 1'($urandom));
    i_lcdcr_ctrl_model.pulse(1'b1, 8'h00, 1'b0, 1'($urandom));
    for (int i = base; i < base + n*w; i++) exp_l2[i] = exp_l1[i];
    @(negedge ref_clk);
    check_out(levels(exp_l2, ac_phase));
    check_bit("chain", 1'b1, chain_enable_out_n);
    check_bit("standby", 1'b0, standby);
  endtask : col_line

  // One scan bit walked through the whole window
  task automatic row_scan(input logic c80, input logic dir);
    int lo, hi;
    lo = c80 ? 40 : 0;
    hi = c80 ? 119 : 159;
    @(posedge ref_clk);
    function_select     <= 1'b0;
    output_count_select <= c80;
    shift_direction     <= dir;
    for (int s = 0; s <= hi - lo; s++) begin
      i_lcdcr_ctrl_model.pulse(1'b0, 8'h00, s == 0, 1'($urandom));
      if (dir) begin
        for (int i = hi; i > lo; i--) exp_l2[i] = exp_l2[i-1];
        exp_l2[lo] = (s == 0);
      end else begin
        for (int i = lo; i < hi; i++) exp_l2[i] = exp_l2[i+1];
        exp_l2[hi] = (s == 0);
      end
      @(negedge ref_clk);
      check_out(levels(exp_l2, ac_phase));
      check_bit("chain", dir ? exp_l2[hi] : exp_l2[lo], chain_enable_out_n);
    end
  endtask : row_scan

  // Clock enable low across a whole scan pulse: the pulse must leave no trace
  task automatic freeze_check();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    i_lcdcr_ctrl_model.pulse(1'b0, 8'h00, 1'b1, ac_phase);
    clk_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check_out(levels(exp_l2, ac_phase));
    check_bit("chain", exp_l2[119], chain_enable_out_n);
  endtask : freeze_check

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Hang guard, well above the roughly 6500 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // Main sequence: column modes from a table, row scans in all four mode pairs, a frozen pulse
  initial begin
    rst_n               = 1'b0;
    clk_en              = 1'b1;
    shift_direction     = 1'b0;
    input_width_select  = 1'b1;
    function_select     = 1'b1;
    output_count_select = 1'b0;
    void'($urandom(44));
    do_reset();
    for (int c = 0; c < 4; c++) col_line(cfg[c][2], cfg[c][1], cfg[c][0]);
    do_reset();
    row_scan(1'b0, 1'b1);
    row_scan(1'b1, 1'b0);
    row_scan(1'b0, 1'b0);
    row_scan(1'b1, 1'b1);
    freeze_check();
    stop_test();
  end
endmodule : test_lcd_column_row_driver
